//--- core/fps_seq.sv
// flash program / erase sequencer with the virtual flash control word
// assumes the cpu presents one access per cycle and the array macro obeys arr commands
`timescale 1ns/10ps
`include "fps_map.svh"

module fps_seq
  import fps_pkg::*;
#(
  parameter int unsigned PULSE_CYC0 = `FPS_PULSE_0,
  parameter int unsigned PULSE_CYC1 = `FPS_PULSE_1,
  parameter int unsigned PULSE_CYC2 = `FPS_PULSE_2,
  parameter int unsigned PULSE_CYC3 = `FPS_PULSE_3
)
(
  input wire logic clock, // 100 MHz cpu clock
  input wire logic rst, // synchronous reset, active high
  input wire fps_acc_t acc, // cpu access to flash space
  input wire logic [15:0] arr_rdata, // array read data
  input wire logic vpp_ok, // programming supply above threshold, async pin
  output logic [15:0] rdata, // read data to cpu
  output logic rvalid, // read data valid, one cycle pulse
  output fps_arr_t arr, // array command
  output logic busy, // operation in progress
  output logic write_mode // write mode active
);

  ////////////////////////////////////////////////////////////////////////////
  fps_state_t s_reg;
  fps_state_t s_next;

  function automatic logic [18:0] pulse_len(input logic [1:0] sel);
    case (sel)
      2'b00: pulse_len = PULSE_CYC0[18:0];
      2'b01: pulse_len = PULSE_CYC1[18:0];
      2'b10: pulse_len = PULSE_CYC2[18:0];
      2'b11: pulse_len = PULSE_CYC3[18:0];
      default: pulse_len = PULSE_CYC0[18:0];
    endcase
  endfunction : pulse_len

  function automatic logic [15:0] ctrl_word(input fps_state_t st);
    ctrl_word = `FPS_CTRL_RESET;
    ctrl_word[`FPS_B_WMODE] = st.wmode;
    ctrl_word[`FPS_B_BANK_HI:`FPS_B_BANK_LO] = st.bank;
    ctrl_word[`FPS_B_DWORD] = st.dword;
    ctrl_word[`FPS_B_TSEL_HI:`FPS_B_TSEL_LO] = st.tsel;
    ctrl_word[`FPS_B_VPP_OK] = st.vpp_s2;
    ctrl_word[`FPS_B_DROPOUT] = st.dropout;
    ctrl_word[`FPS_B_BUSY] = (st.op != FPS_IDLE);
    ctrl_word[`FPS_B_ERASE] = st.erase_sel;
    ctrl_word[`FPS_B_WREN] = st.wren;
  endfunction : ctrl_word

  logic even;
  logic dwr;
  logic iwr;
  logic self_wr;
  logic is_busy;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    even = ~acc.addr[0];
    dwr = acc.valid & acc.write & ~acc.indirect & even;
    iwr = acc.valid & acc.write & acc.indirect & even;
    self_wr = iwr & (acc.data == acc.addr[15:0]);
    is_busy = (s_reg.op != FPS_IDLE);
    s_next.vpp_s1 = vpp_ok;
    s_next.vpp_s2 = s_reg.vpp_s1;
    s_next.rvalid = 1'b0;
    s_next.arr.prog = 1'b0;
    s_next.arr.erase = 1'b0;
    // reads: control word for direct reads in write mode, array otherwise
    if (acc.valid && !acc.write)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = (s_reg.wmode && !acc.indirect) ? ctrl_word(s_reg) : arr_rdata;
    end
    // pulse timer
    if (is_busy)
    begin
      s_next.cnt = s_reg.cnt + 19'd1;
      if (!s_reg.vpp_s2)
        s_next.dropout = 1'b1;
      if (s_reg.cnt == pulse_len(s_reg.tsel) - 19'd1)
      begin
        s_next.op = FPS_IDLE;
        if (s_reg.op == FPS_PROG)
          s_next.arr.prog_verify = 1'b1;
        else
          s_next.arr.erase_verify = 1'b1;
      end
    end
    else if (!s_reg.wmode)
    begin
      // unlock key: direct dummy write, then indirect self-address write as the very next access
      // idle cycles between the two accesses keep the key armed, a further direct dummy write re-arms it, any other access disarms it
      if (acc.valid)
      begin
        s_next.key_armed = dwr;
        if (self_wr && s_reg.key_armed)
          s_next.wmode = 1'b1;
      end
    end
    else if (dwr)
    begin
      if (!acc.data[`FPS_B_WMODE])
      begin
        s_next.wmode = 1'b0;
        s_next.bank = 2'b00;
        s_next.dword = 1'b0;
        s_next.tsel = 2'b00;
        s_next.erase_sel = 1'b0;
        s_next.wren = 1'b0;
        s_next.arr.prog_verify = 1'b0;
        s_next.arr.erase_verify = 1'b0;
      end
      else
      begin
        s_next.bank = acc.data[`FPS_B_BANK_HI:`FPS_B_BANK_LO];
        s_next.dword = acc.data[`FPS_B_DWORD];
        s_next.tsel = acc.data[`FPS_B_TSEL_HI:`FPS_B_TSEL_LO];
        s_next.erase_sel = acc.data[`FPS_B_ERASE];
        s_next.wren = acc.data[`FPS_B_WREN];
        if (!acc.data[`FPS_B_WREN])
        begin
          s_next.arr.prog_verify = 1'b0;
          s_next.arr.erase_verify = 1'b0;
        end
      end
      s_next.have_first = 1'b0;
    end
    else if (iwr && s_reg.wren && s_reg.erase_sel)
    begin
      if (self_wr && !s_reg.dword)
      begin
        s_next.op = FPS_ERASE;
        s_next.cnt = 19'd0;
        s_next.dropout = ~s_reg.vpp_s2;
        s_next.arr.erase = 1'b1;
        s_next.arr.bank = s_reg.bank;
        s_next.arr.erase_verify = 1'b0;
      end
    end
    else if (iwr && s_reg.wren)
    begin
      if (s_reg.dword && !s_reg.have_first)
      begin
        s_next.have_first = acc.addr[1:0] == 2'b00;
        s_next.arr.addr = acc.addr;
        s_next.arr.data[15:0] = acc.data;
      end
      else if (s_reg.dword && acc.addr != s_reg.arr.addr + `FPS_WORD_STEP)
      begin
        s_next.have_first = acc.addr[1:0] == 2'b00;
        s_next.arr.addr = acc.addr;
        s_next.arr.data[15:0] = acc.data;
      end
      else
      begin
        s_next.op = FPS_PROG;
        s_next.cnt = 19'd0;
        s_next.dropout = ~s_reg.vpp_s2;
        s_next.have_first = 1'b0;
        s_next.arr.prog = 1'b1;
        s_next.arr.dword = s_reg.dword;
        s_next.arr.prog_verify = 1'b0;
        s_next.arr.erase_verify = 1'b0;
        if (s_reg.dword)
          s_next.arr.data[31:16] = acc.data;
        else
        begin
          s_next.arr.addr = acc.addr;
          s_next.arr.data = {16'h0000, acc.data};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rdata = s_reg.rdata;
  assign rvalid = s_reg.rvalid;
  assign arr = s_reg.arr;
  assign busy = s_reg.op != FPS_IDLE;
  assign write_mode = s_reg.wmode;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_exit_write_mode: assert property (
    s_reg.wmode && !busy && acc.valid && acc.write && !acc.indirect && !acc.addr[0] && !acc.data[`FPS_B_WMODE]
    |=> !write_mode && !s_reg.wren)
    else $error("write mode not left on exit write");
  a_unlock_key: assert property (
    !s_reg.wmode && s_reg.key_armed && acc.valid && acc.write && acc.indirect && !acc.addr[0]
    && acc.data == acc.addr[15:0] |=> write_mode)
    else $error("unlock sequence did not set write mode");
  a_prog_start: assert property (
    $rose(arr.prog) |-> busy && !arr.erase && s_reg.op == FPS_PROG)
    else $error("program pulse without busy");
  a_short_pulse: assert property (
    $rose(busy) && s_reg.tsel == 2'b00 |-> busy [*8] ##[2:393] $fell(busy))
    else $error("shortest pulse length wrong");
  a_verify_after: assert property (
    $fell(busy) && $past(s_reg.op) == FPS_PROG |-> arr.prog_verify && s_reg.wren)
    else $error("program verify not entered");
  a_erase_verify: assert property (
    $fell(busy) && $past(s_reg.op) == FPS_ERASE |-> arr.erase_verify && s_reg.wren && s_reg.erase_sel)
    else $error("erase verify not entered");
  a_erase_needs_mode: assert property (
    arr.erase |-> $past(s_reg.wmode) && $past(s_reg.erase_sel) && arr.bank == $past(s_reg.bank))
    else $error("erase outside write mode or wrong bank");
  a_erase_cmd_only: assert property (
    arr.erase |-> $past(acc.data) == $past(acc.addr[15:0]) && !$past(s_reg.dword))
    else $error("erase without self address command");
  a_dropout_latch: assert property (
    busy && !s_reg.vpp_s2 |=> s_reg.dropout [*2])
    else $error("supply dropout not latched");
  a_busy_readback: assert property (
    acc.valid && !acc.write && !acc.indirect && s_reg.wmode |=> rvalid && rdata[`FPS_B_BUSY] == $past(busy))
    else $error("busy bit readback wrong");
endmodule : fps_seq

//--- core/fps_map.svh
// flash control word layout, reset value and pulse lengths for the flash sequencer
// assumes 16-bit flash words, byte addresses with bit 0 as the byte select
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH
`define FPS_B_WMODE 15
`define FPS_B_BANK_HI 9
`define FPS_B_BANK_LO 8
`define FPS_B_DWORD 7
`define FPS_B_TSEL_HI 6
`define FPS_B_TSEL_LO 5
`define FPS_B_VPP_OK 4
`define FPS_B_DROPOUT 3
`define FPS_B_BUSY 2
`define FPS_B_ERASE 1
`define FPS_B_WREN 0
`define FPS_CTRL_RESET 16'h0000
`define FPS_WORD_STEP 18'h00002
`define FPS_PULSE_0 400
`define FPS_PULSE_1 4000
`define FPS_PULSE_2 40000
`define FPS_PULSE_3 400000
`endif

//--- core/fps_pkg.sv
// types shared by the flash program and erase sequencer
// assumes nothing beyond the constants header
package fps_pkg;
  typedef enum logic [1:0]
  {
    FPS_IDLE = 2'b00,
    FPS_PROG = 2'b01,
    FPS_ERASE = 2'b10
  } fps_op_t;

  // one cpu access to the flash space
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic [17:0] addr;
    logic [15:0] data;
  } fps_acc_t;

  // commands to the flash array macro
  typedef struct packed {
    logic prog;
    logic erase;
    logic dword;
    logic [1:0] bank;
    logic [17:0] addr;
    logic [31:0] data;
    logic prog_verify;
    logic erase_verify;
  } fps_arr_t;

  typedef struct packed {
    fps_op_t op;
    logic wmode;
    logic [1:0] bank;
    logic dword;
    logic [1:0] tsel;
    logic dropout;
    logic erase_sel;
    logic wren;
    logic key_armed;
    logic have_first;
    logic [18:0] cnt;
    logic vpp_s1;
    logic vpp_s2;
    fps_arr_t arr;
    logic [15:0] rdata;
    logic rvalid;
  } fps_state_t;
endpackage : fps_pkg

//--- tb/fps_array_model.sv
// behavioural flash array behind the sequencer
// assumes 16 words seen through byte address bits 4:1
`timescale 1ns/10ps
module fps_array_model
  import fps_pkg::*;
(
  input wire logic clock, // cpu clock
  input wire fps_arr_t arr, // command from the sequencer
  input wire logic [17:0] rd_addr, // current read address
  output logic [15:0] rdata // array data, combinational
);
  logic [15:0] mem [0:15];
  always_ff @(posedge clock)
  begin
    if (arr.erase)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 16'hffff;
    end
    else if (arr.prog)
    begin
      mem[arr.addr[4:1]] <= arr.data[15:0];
      if (arr.dword)
        mem[arr.addr[4:1] + 4'h1] <= arr.data[31:16];
    end
  end
  assign rdata = mem[rd_addr[4:1]];
endmodule : fps_array_model

//--- tb/flash_program_erase_sequencer_tb.sv
// self-checking bench for the flash sequencer
// assumes short pulse counts 10,20,30,40 and the array model as far side
`timescale 1ns/10ps
module flash_program_erase_sequencer_tb;
  import fps_pkg::*;
  logic clock, rst, vpp_ok, rvalid, busy, write_mode;
  fps_acc_t acc;
  fps_arr_t arr;
  logic [15:0] arr_rdata, rdata, d1, d2;
  logic [31:0] seed = 32'he0aeb9db;
  logic [17:0] a;
  logic [1:0] bk;
  int failures, n_compared, n;
  fps_seq #(.PULSE_CYC0(10), .PULSE_CYC1(20), .PULSE_CYC2(30), .PULSE_CYC3(40)) dut (.clock(clock), .rst(rst),
    .acc(acc), .arr_rdata(arr_rdata), .vpp_ok(vpp_ok), .rdata(rdata), .rvalid(rvalid), .arr(arr), .busy(busy),
    .write_mode(write_mode));
  fps_array_model mem (.clock(clock), .arr(arr), .rd_addr(acc.addr), .rdata(arr_rdata));
  ////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function int pulse(input logic [1:0] t);
    return 10 * (int'(t) + 1);
  endfunction : pulse
  function logic [15:0] ctl(input logic [1:0] b, input logic dw, input logic [1:0] t, input logic vp, dr, er, we);
    return {1'b1, 5'h00, b, dw, t, vp, dr, 1'b0, er, we};
  endfunction : ctl
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task access(input logic w, ind, input logic [17:0] ad, input logic [15:0] dt);
    @(negedge clock);
    acc <= {1'b1, w, ind, ad, dt};
    @(negedge clock);
    acc.valid <= 1'b0;
  endtask : access
  task rd(input logic ind, input logic [17:0] ad, input logic [15:0] exp);
    access(1'b0, ind, ad, 16'h0000);
    chk(rvalid, 1);
    chk(rdata, exp);
  endtask : rd
  task wr_ctl(input logic [1:0] b, input logic dw, input logic [1:0] t, input logic er, we);
    access(1'b1, 1'b0, 18'h00200, {1'b1, 5'h00, b, dw, t, 3'b000, er, we});
  endtask : wr_ctl
  task wait_busy();
    n = 0;
    // polls the busy pin only, no array read while an operation runs
    while (busy === 1'b1 && n < 100)
    begin
      n++;
      @(negedge clock);
    end
  endtask : wait_busy
  task end_sim();
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    acc = '0;
    vpp_ok = 1'b1;
    failures = 0;
    n_compared = 0;
    repeat (2) @(negedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(busy, 0);
    chk(write_mode, 0);
    access(1'b1, 1'b0, 18'h00040, 16'h1234);
    access(1'b1, 1'b1, 18'h00404, 16'h0404);
    @(negedge clock);
    chk(write_mode, 1);
    rd(1'b0, 18'h00100, ctl(2'b00, 0, 2'b00, 1, 0, 0, 0));
    // zero the whole bank first, then erase with the supply low, after a refused wrong command
    bk = 2'(rnd());
    wr_ctl(bk, 1'b0, 2'b00, 1'b0, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      access(1'b1, 1'b1, 18'(2 * i), 16'h0000);
      wait_busy();
    end
    rd(1'b1, 18'h0001e, 16'h0000);
    vpp_ok <= 1'b0;
    wr_ctl(bk, 1'b0, 2'b01, 1'b1, 1'b1);
    a = 18'(rnd() & 32'h1c);
    access(1'b1, 1'b1, a, ~a[15:0]);
    chk(arr.erase, 0);
    chk(busy, 0);
    access(1'b1, 1'b1, a, a[15:0]);
    chk(arr.erase, 1);
    chk(arr.bank, bk);
    wait_busy();
    chk(n, pulse(2'b01));
    chk(arr.erase_verify, 1);
    rd(1'b0, 18'h00100, ctl(bk, 0, 2'b01, 0, 1, 1, 1));
    for (int i = 0; i < 16; i++)
      rd(1'b1, 18'(2 * i), 16'hffff);
    vpp_ok <= 1'b1;
    // single word program at every timer code
    for (int t = 0; t < 4; t++)
    begin
      wr_ctl(2'b00, 1'b0, 2'(t), 1'b0, 1'b1);
      d1 = 16'(rnd());
      a = 18'(rnd() & 32'h1c);
      access(1'b1, 1'b1, a, d1);
      chk(arr.prog, 1);
      chk(arr.addr, a);
      chk(arr.data[15:0], d1);
      wait_busy();
      chk(n, pulse(2'(t)));
      chk(arr.prog_verify, 1);
      rd(1'b0, 18'h00100, ctl(2'b00, 0, 2'(t), 1, 0, 0, 1));
      access(1'b0, 1'b1, a, 16'h0000);
      repeat (400) @(negedge clock);
      rd(1'b1, a, d1);
    end
    // double word pair
    wr_ctl(2'b00, 1'b1, 2'b00, 1'b0, 1'b1);
    d1 = 16'(rnd());
    d2 = 16'(rnd());
    a = 18'(rnd() & 32'h1c);
    access(1'b1, 1'b1, a, d1);
    chk(busy, 0);
    access(1'b1, 1'b1, a + 18'h00002, d2);
    chk(arr.dword, 1);
    chk(arr.data, {d2, d1});
    wait_busy();
    chk(n, pulse(2'b00));
    rd(1'b1, a + 18'h00002, d2);
    // drop write-enable for normal reads, then leave write mode; a data write must not program
    wr_ctl(2'b00, 1'b1, 2'b00, 1'b0, 1'b0);
    chk(arr.prog_verify, 0);
    rd(1'b1, a, d1);
    access(1'b1, 1'b0, 18'h00300, 16'h0000);
    @(negedge clock);
    chk(write_mode, 0);
    access(1'b1, 1'b1, a, 16'h5555);
    chk(busy, 0);
    end_sim();
  end
endmodule : flash_program_erase_sequencer_tb
